// >>> arlm_pkg.sv
// arlm_pkg: constants for the analog reference loss monitor
// assumes a 20 MHz ref_clk and an APB slave with 32-bit data
// Notes on behaviour
// - each input selector takes codes 0,1,2,3,5,6,7,8,10,11,20; others ignored
// - auxiliary frequency 1 adds only to the primary frequency source
// - auxiliary frequency 2 adds to primary, secondary and preset-step references
// - ratio input multiplies the final frequency command
// - duplicate codes: selector a beats b, b beats c
// - save mode 0 stores keypad reference at power-off, restores at power-on
// - save mode 1 stores only on save key; last saved restored at power-on
// - level under 10% of last sample within 400 ms means loss; run at ratio
// - analog command level is sampled again every fixed interval
// - loss response accepts 0 stop, 20 to 120 ratio, 999 disable
// - with 999 the loss flag rises but the analog command is still followed
// - level above recovery threshold ends loss; analog command followed again
// - for 0 or 999 recovery threshold is 0.2 of pre-loss level
// - for 100 to 120 recovery threshold is the full pre-loss level
// - loss is judged on the raw unfiltered input level
package arlm_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_FUNC_SEL   = 8'h00;
   localparam logic [7:0] OFS_CTRL       = 8'h04;
   localparam logic [7:0] OFS_LOSS_RATIO = 8'h08;
   localparam logic [7:0] OFS_KEYPAD_REF = 8'h0C;
   localparam logic [7:0] OFS_SAVED_REF  = 8'h10;
   localparam logic [7:0] OFS_STATUS     = 8'h14;
   localparam logic [7:0] OFS_INT_STAT   = 8'h18;
   localparam logic [7:0] OFS_INT_MASK   = 8'h1C;
   localparam logic [7:0] OFS_FREQ_OUT   = 8'h20;
   localparam logic [7:0] OFS_PRE_LOSS   = 8'h24;
   // field positions
   localparam int SEL_A_LSB = 0;
   localparam int SEL_B_LSB = 8;
   localparam int SEL_C_LSB = 16;
   localparam int SAVE_MODE_BIT = 0;
   localparam int FREQ_IN_LSB = 4;
   // function codes
   localparam logic [4:0] FN_NONE = 5'h00;
   localparam logic [4:0] FN_AUX1 = 5'h01;
   localparam logic [4:0] FN_AUX2 = 5'h02;
   localparam logic [4:0] FN_PID_CMD = 5'h03;
   localparam logic [4:0] FN_PID_FB = 5'h05;
   localparam logic [4:0] FN_RATIO = 5'h06;
   localparam logic [4:0] FN_TLIM_A = 5'h07;
   localparam logic [4:0] FN_TLIM_B = 5'h08;
   localparam logic [4:0] FN_TRQ_CMD = 5'h0A;
   localparam logic [4:0] FN_TRQ_CUR = 5'h0B;
   localparam logic [4:0] FN_MONITOR = 5'h14;
   // loss response settings
   localparam logic [9:0] LR_STOP = 10'd0;
   localparam logic [9:0] LR_MIN = 10'd20;
   localparam logic [9:0] LR_FULL = 10'd100;
   localparam logic [9:0] LR_MAX = 10'd120;
   localparam logic [9:0] LR_DISABLE = 10'd999;
   localparam logic [9:0] LR_RESET = LR_DISABLE;
   // loss detection figures
   localparam int LOSS_PCT = 10;
   localparam int RECOVER_DIV = 5;
   localparam int RATIO_SHIFT = 11;
   // timing
   localparam int CLK_HZ = 20_000_000;
   localparam int LOSS_WINDOW_MS = 400;
   localparam int LOSS_WINDOW_CYC = LOSS_WINDOW_MS * (CLK_HZ / 1000);
   // interrupt bits
   localparam int IRQ_LOSS = 0;
   localparam int IRQ_RECOVER = 1;
   localparam int IRQ_SAVED = 2;
   // reference source select
   localparam logic [1:0] SRC_PRIMARY = 2'd0;
   localparam logic [1:0] SRC_SECONDARY = 2'd1;
   localparam logic [1:0] SRC_STEP = 2'd2;
endpackage

// >>> arlm_top.sv
// arlm_top: analog input function routing, keypad reference save
// and analog reference loss supervision with an APB register file
// assumes all inputs synchronous to ref_clk, rst asynchronous high
`timescale 1ns/1ps
`default_nettype none
module arlm_top #(
   parameter int LOSS_WINDOW_CYCLES = arlm_pkg::LOSS_WINDOW_CYC
) (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   input  wire logic [11:0] input_a_level,
   input  wire logic [11:0] input_b_level,
   input  wire logic [11:0] input_c_level,
   input  wire logic [1:0]  ref_select,
   input  wire logic [15:0] secondary_ref,
   input  wire logic [15:0] step_ref,
   input  wire logic        save_key,
   input  wire logic        power_off,
   input  wire logic        power_on,
   output var  logic [15:0] freq_cmd,
   output var  logic        ref_loss,
   output var  logic        decel_stop,
   output var  logic [11:0] pid_command,
   output var  logic [11:0] pid_feedback,
   output var  logic [11:0] torque_limit_a,
   output var  logic [11:0] torque_limit_b,
   output var  logic [11:0] torque_command,
   output var  logic [11:0] torque_current_command,
   output var  logic [11:0] monitor_level,
   output var  logic        irq
);
   import arlm_pkg::*;

   typedef struct packed {
      logic [4:0]       sel_a;
      logic [4:0]       sel_b;
      logic [4:0]       sel_c;
      logic             save_mode;
      logic [1:0]       freq_in;
      logic [9:0]       ratio;
      logic [15:0]      keypad;
      logic [15:0]      saved;
      logic [2:0]       ist;
      logic [2:0]       imask;
      logic             irq;
      logic [31:0]      prdata;
      logic             pready;
      logic             pslverr;
      logic [23:0]      cnt;
      logic [11:0]      f1;
      logic             loss;
      logic             stop;
      logic [15:0]      freq;
      logic [6:0][11:0] fv;
   } arlm_state_t;

   arlm_state_t s;
   arlm_state_t next_s;

   // codes accepted by a selector
   function automatic logic arlm_code_ok(input logic [4:0] c);
      case (c)
         FN_NONE, FN_AUX1, FN_AUX2, FN_PID_CMD, FN_PID_FB, FN_RATIO,
         FN_TLIM_A, FN_TLIM_B, FN_TRQ_CMD, FN_TRQ_CUR, FN_MONITOR: arlm_code_ok = 1'b1;
         default: arlm_code_ok = 1'b0;
      endcase
   endfunction

   // first selector holding a code: 0 a, 1 b, 2 c, 3 none
   function automatic logic [1:0] arlm_pick(input logic [4:0] a, input logic [4:0] b,
                                            input logic [4:0] c, input logic [4:0] code);
      if (a == code) begin
         arlm_pick = 2'd0;
      end else if (b == code) begin
         arlm_pick = 2'd1;
      end else if (c == code) begin
         arlm_pick = 2'd2;
      end else begin
         arlm_pick = 2'd3;
      end
   endfunction

   // function codes routed to the plain value outputs
   localparam logic [6:0][4:0] FV_CODE = {FN_MONITOR, FN_TRQ_CUR, FN_TRQ_CMD,
                                          FN_TLIM_B, FN_TLIM_A, FN_PID_FB, FN_PID_CMD};

   logic [3:0][11:0] an;
   logic [11:0]      lvl;
   logic [1:0]       idx;
   logic [11:0]      aux1;
   logic [11:0]      aux2;
   logic [11:0]      rlvl;
   logic             has_ratio;
   logic [11:0]      thr;
   logic [15:0]      sub;
   logic [15:0]      prim;
   logic [15:0]      base;
   logic [17:0]      sum;
   logic [29:0]      prod;
   logic [15:0]      lvl10;
   logic             tick;
   logic             wr;
   logic [2:0]       iset;
   logic [31:0]      rd;
   logic             hit;

   assign an = {12'h000, input_c_level, input_b_level, input_a_level};
   assign wr = psel & penable & s.pready;

   // apb read mux, evaluated in the setup cycle
   always_comb begin
      hit = 1'b1;
      rd = 32'h0000_0000;
      case (paddr)
         OFS_FUNC_SEL: begin
            rd[SEL_A_LSB +: 5] = s.sel_a;
            rd[SEL_B_LSB +: 5] = s.sel_b;
            rd[SEL_C_LSB +: 5] = s.sel_c;
         end
         OFS_CTRL: begin
            rd[SAVE_MODE_BIT] = s.save_mode;
            rd[FREQ_IN_LSB +: 2] = s.freq_in;
         end
         OFS_LOSS_RATIO: rd[9:0] = s.ratio;
         OFS_KEYPAD_REF: rd[15:0] = s.keypad;
         OFS_SAVED_REF: rd[15:0] = s.saved;
         OFS_STATUS: rd[1:0] = {s.stop, s.loss};
         OFS_INT_STAT: rd[2:0] = s.ist;
         OFS_INT_MASK: rd[2:0] = s.imask;
         OFS_FREQ_OUT: rd[15:0] = s.freq;
         OFS_PRE_LOSS: rd[11:0] = s.f1;
         default: hit = 1'b0;
      endcase
   end

   // analog frequency input, auxiliary and ratio inputs
   always_comb begin
      lvl = an[2'(s.freq_in - 2'd1)];
      idx = arlm_pick(s.sel_a, s.sel_b, s.sel_c, FN_AUX1);
      aux1 = an[idx];
      idx = arlm_pick(s.sel_a, s.sel_b, s.sel_c, FN_AUX2);
      aux2 = an[idx];
      idx = arlm_pick(s.sel_a, s.sel_b, s.sel_c, FN_RATIO);
      rlvl = an[idx];
      has_ratio = (idx != 2'd3);
   end

   // recovery threshold and substitute frequency from the pre-loss level
   always_comb begin
      sub = 16'((22'(s.f1) * 22'(s.ratio)) / 22'd100);
      if (s.ratio == LR_STOP || s.ratio == LR_DISABLE) begin
         thr = 12'(s.f1 / 12'(RECOVER_DIV));
      end else if (s.ratio >= LR_FULL) begin
         thr = s.f1;
      end else begin
         thr = 12'(sub);
      end
      lvl10 = 16'(lvl) * 16'(LOSS_PCT);
   end

   // reference selection, auxiliary addition and ratio
   always_comb begin
      if (s.freq_in == 2'd0) begin
         prim = s.keypad;
      end else if (s.loss && s.ratio == LR_STOP) begin
         prim = 16'h0000;
      end else if (s.loss && s.ratio != LR_DISABLE) begin
         prim = sub;
      end else begin
         prim = 16'(lvl);
      end
      case (ref_select)
         SRC_PRIMARY: base = prim;
         SRC_SECONDARY: base = secondary_ref;
         SRC_STEP: base = step_ref;
         default: base = prim;
      endcase
      sum = 18'(base) + 18'(aux2);
      // code 3 also selects the primary source, so it takes auxiliary 1 as well
      if (ref_select != SRC_SECONDARY && ref_select != SRC_STEP) begin
         sum = sum + 18'(aux1);
      end
      prod = 30'(sum) * 30'(rlvl);
      if (has_ratio) begin
         sum = 18'(prod >> RATIO_SHIFT);
      end
   end

   // next state of the whole block
   always_comb begin
      next_s = s;
      iset = 3'b000;
      tick = (s.cnt == 24'(LOSS_WINDOW_CYCLES - 1));
      // sample interval timer
      next_s.cnt = tick ? 24'h00_0000 : s.cnt + 24'h00_0001;
      // apb answer: data and ready loaded in setup, zero wait states
      next_s.pready = psel & ~penable;
      next_s.pslverr = psel & ~penable & ~hit;
      if (psel & ~penable) begin
         next_s.prdata = pwrite ? 32'h0000_0000 : rd;
      end
      // register writes at the access edge
      if (wr && pwrite) begin
         case (paddr)
            OFS_FUNC_SEL: begin
               if (arlm_code_ok(pwdata[SEL_A_LSB +: 5])) begin
                  next_s.sel_a = pwdata[SEL_A_LSB +: 5];
               end
               if (arlm_code_ok(pwdata[SEL_B_LSB +: 5])) begin
                  next_s.sel_b = pwdata[SEL_B_LSB +: 5];
               end
               if (arlm_code_ok(pwdata[SEL_C_LSB +: 5])) begin
                  next_s.sel_c = pwdata[SEL_C_LSB +: 5];
               end
            end
            OFS_CTRL: begin
               next_s.save_mode = pwdata[SAVE_MODE_BIT];
               next_s.freq_in = pwdata[FREQ_IN_LSB +: 2];
            end
            OFS_LOSS_RATIO: begin
               if (pwdata[9:0] == LR_STOP || pwdata[9:0] == LR_DISABLE ||
                   (pwdata[9:0] >= LR_MIN && pwdata[9:0] <= LR_MAX)) begin
                  next_s.ratio = pwdata[9:0];
               end
            end
            OFS_KEYPAD_REF: next_s.keypad = pwdata[15:0];
            OFS_INT_STAT: next_s.ist = s.ist & ~pwdata[2:0];
            OFS_INT_MASK: next_s.imask = pwdata[2:0];
            default: next_s.ist = next_s.ist;
         endcase
      end
      // keypad reference save and restore
      if (power_off && s.save_mode == 1'b0) begin
         next_s.saved = s.keypad;
         iset[IRQ_SAVED] = 1'b1;
      end else if (save_key && s.save_mode == 1'b1) begin
         next_s.saved = s.keypad;
         iset[IRQ_SAVED] = 1'b1;
      end
      if (power_on) begin
         next_s.keypad = s.saved;
      end
      // loss detection and recovery
      if (s.freq_in == 2'd0) begin
         next_s.loss = 1'b0;
      end else if (!s.loss) begin
         if (tick) begin
            if (lvl10 < 16'(s.f1)) begin
               next_s.loss = 1'b1;
               iset[IRQ_LOSS] = 1'b1;
            end else begin
               next_s.f1 = lvl;
            end
         end
      end else if (lvl > thr) begin
         next_s.loss = 1'b0;
         next_s.f1 = lvl;
         iset[IRQ_RECOVER] = 1'b1;
      end
      next_s.stop = next_s.loss && s.ratio == LR_STOP;
      // sticky status: a set beats a clear in the same cycle
      next_s.ist = next_s.ist | iset;
      next_s.irq = |(next_s.ist & next_s.imask);
      // outputs
      next_s.freq = (sum > 18'h0FFFF) ? 16'hFFFF : sum[15:0];
      for (int k = 0; k < 7; k++) begin
         next_s.fv[k] = an[arlm_pick(s.sel_a, s.sel_b, s.sel_c, FV_CODE[k])];
      end
   end

   // state register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s <= '0;
         s.ratio <= LR_RESET;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from the state flops
   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign freq_cmd = s.freq;
   assign ref_loss = s.loss;
   assign decel_stop = s.stop;
   assign irq = s.irq;
   assign pid_command = s.fv[0];
   assign pid_feedback = s.fv[1];
   assign torque_limit_a = s.fv[2];
   assign torque_limit_b = s.fv[3];
   assign torque_command = s.fv[4];
   assign torque_current_command = s.fv[5];
   assign monitor_level = s.fv[6];
endmodule
`default_nettype wire

// >>> arlm_monitor.sv
// arlm_monitor: port-level assertions for arlm_top
// bound into arlm_top from tb_top; sees only its ports
`timescale 1ns/1ps
`default_nettype none
module arlm_monitor
   import arlm_pkg::*;
#(
   parameter int LOSS_WINDOW_CYCLES = 16
) (
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [11:0] input_a_level,
   input wire logic [11:0] input_b_level,
   input wire logic [11:0] input_c_level,
   input wire logic        ref_loss,
   input wire logic        decel_stop,
   input wire logic [11:0] pid_command,
   input wire logic [11:0] monitor_level
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // register bus answers: zero wait, one cycle, error only off the map
   AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
      else $error("pready outside access");
   AST_ZERO_WAIT: assert property (psel && penable |-> pready)
      else $error("access not answered at once");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   AST_ERR_MAP: assert property (pready |-> pslverr == (paddr > OFS_PRE_LOSS || paddr[1:0] != 2'h0))
      else $error("pslverr wrong for address");
   AST_RDATA_HOLD: assert property ($changed(prdata) |-> $past(psel && !penable))
      else $error("prdata moved outside setup");
   // loss output and routed levels
   AST_STOP_IN_LOSS: assert property (decel_stop |-> ref_loss)
      else $error("stop without loss");
   AST_MON_SRC: assert property (monitor_level != 12'h000 |-> monitor_level == $past(input_a_level)
      || monitor_level == $past(input_b_level) || monitor_level == $past(input_c_level))
      else $error("monitor level from nowhere");
   AST_PID_SRC: assert property (pid_command != 12'h000 |-> pid_command == $past(input_a_level)
      || pid_command == $past(input_b_level) || pid_command == $past(input_c_level))
      else $error("pid command from nowhere");
   cover property ($rose(ref_loss));
   cover property ($fell(ref_loss));
   cover property (decel_stop);
   cover property (pslverr);
endmodule
`default_nettype wire

// >>> arlm_sensor_model.sv
// arlm_sensor_model: analog sensors feeding the three raw levels
// levels follow the bench targets one clock later; zero in reset
`timescale 1ns/1ps
`default_nettype none
module arlm_sensor_model (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic [11:0] set_a,
   input  wire logic [11:0] set_b,
   input  wire logic [11:0] set_c,
   output var  logic [11:0] level_a,
   output var  logic [11:0] level_b,
   output var  logic [11:0] level_c
);
   // steps come only when the bench changes a target level
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         level_a <= '0;
         level_b <= '0;
         level_c <= '0;
      end else begin
         level_a <= set_a;
         level_b <= set_b;
         level_c <= set_c;
      end
   end
endmodule
`default_nettype wire

// >>> tb_top.sv
// tb_top: self-checking bench for arlm_top
// apb master, keypad pulses and sensor model; loss window cut to 16
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import arlm_pkg::*;
   localparam int LW = 16;
   logic        ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic        pready, pslverr, save_key = 0, power_off = 0, power_on = 0;
   logic [11:0] la = 0, lb = 0, lc = 0, ia, ib, ic, pid, mon;
   logic [11:0] pfb, tla, tlb, trq, tcur;
   logic [1:0]  ref_select = 0;
   logic [15:0] secondary_ref = 0, step_ref = 0, freq_cmd, rnd = 16'h002A;
   logic        ref_loss, decel_stop, irq;
   logic [32:0] expq[$];
   int          err_count = 0, check_count = 0, n;
   int          rt[4] = '{0, 50, 100, 999};
   int          fl[4] = '{0, 500, 1000, 50};
   int          th[4] = '{200, 500, 1000, 200};
   arlm_sensor_model u_sensor (.ref_clk(ref_clk), .rst(rst), .set_a(la), .set_b(lb),
      .set_c(lc), .level_a(ia), .level_b(ib), .level_c(ic));
   arlm_top #(.LOSS_WINDOW_CYCLES(LW)) DUT (.ref_clk(ref_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .input_a_level(ia), .input_b_level(ib),
      .input_c_level(ic), .ref_select(ref_select), .secondary_ref(secondary_ref),
      .step_ref(step_ref), .save_key(save_key), .power_off(power_off), .power_on(power_on),
      .freq_cmd(freq_cmd), .ref_loss(ref_loss), .decel_stop(decel_stop), .pid_command(pid),
      .pid_feedback(pfb), .torque_limit_a(tla), .torque_limit_b(tlb), .torque_command(trq),
      .torque_current_command(tcur), .monitor_level(mon), .irq(irq));
   // clock
   always #25 ref_clk = ~ref_clk;
   task check(input logic [32:0] seen, input logic [32:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task end_sim;
      if (err_count == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // one apb transfer, held until pready is sampled high
   task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1;
      // wait for the answer however long it takes; the watchdog ends a hang
      do @(posedge ref_clk); while (pready !== 1'b1);
      psel <= 0;
      penable <= 0;
   endtask
   task rd(input logic [7:0] a, input logic [32:0] e);
      expq.push_back(e);
      apb(a, 0, 0);
   endtask
   task wt(input int c);
      repeat (c) @(posedge ref_clk);
   endtask
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // read results: {pslverr, prdata} against the oldest note
   always @(posedge ref_clk)
      if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0)
         check({pslverr, prdata}, expq.pop_front());
   // watchdog
   initial begin
      repeat (20000) @(posedge ref_clk);
      err_count++;
      end_sim;
   end
   initial begin
      repeat (10) @(posedge ref_clk);
      rst <= 0;
      rd(OFS_LOSS_RATIO, {23'h0, LR_RESET});
      rd(OFS_FUNC_SEL, 33'h0);
      rd(8'h40, 33'h100000000);
      // duplicate and invalid selector codes
      apb(OFS_FUNC_SEL, 1, {11'h0, FN_PID_CMD, 3'h0, FN_MONITOR, 3'h0, FN_MONITOR});
      apb(OFS_FUNC_SEL, 1, {11'h0, FN_PID_CMD, 3'h0, FN_MONITOR, 3'h0, 5'h04});
      rd(OFS_FUNC_SEL, {12'h0, FN_PID_CMD, 3'h0, FN_MONITOR, 3'h0, FN_MONITOR});
      la <= 12'h123;
      lb <= 12'h456;
      lc <= 12'h789;
      wt(4);
      check(33'(mon), 33'h123);
      check(33'(pid), 33'h789);
      // the remaining routed outputs, then a duplicate torque command code
      apb(OFS_FUNC_SEL, 1, {11'h0, FN_TLIM_B, 3'h0, FN_TLIM_A, 3'h0, FN_PID_FB});
      wt(2);
      check(33'(pfb), 33'h123);
      check(33'(tla), 33'h456);
      check(33'(tlb), 33'h789);
      check(33'(mon), 33'h000);
      apb(OFS_FUNC_SEL, 1, {11'h0, FN_TRQ_CMD, 3'h0, FN_TRQ_CUR, 3'h0, FN_TRQ_CMD});
      wt(2);
      check(33'(trq), 33'h123);
      check(33'(tcur), 33'h456);
      check(33'(pfb), 33'h000);
      apb(OFS_LOSS_RATIO, 1, 32'd10);
      apb(OFS_LOSS_RATIO, 1, 32'd150);
      rd(OFS_LOSS_RATIO, {23'h0, LR_RESET});
      // keypad save modes
      apb(OFS_KEYPAD_REF, 1, 32'h1111);
      @(posedge ref_clk) power_off <= 1;
      @(posedge ref_clk) power_off <= 0;
      rd(OFS_SAVED_REF, 33'h1111);
      apb(OFS_CTRL, 1, 32'h1);
      apb(OFS_KEYPAD_REF, 1, 32'h2222);
      @(posedge ref_clk) power_off <= 1;
      @(posedge ref_clk) power_off <= 0;
      rd(OFS_SAVED_REF, 33'h1111);
      @(posedge ref_clk) save_key <= 1;
      @(posedge ref_clk) save_key <= 0;
      rd(OFS_SAVED_REF, 33'h2222);
      apb(OFS_KEYPAD_REF, 1, 32'h3333);
      @(posedge ref_clk) power_on <= 1;
      @(posedge ref_clk) power_on <= 0;
      rd(OFS_KEYPAD_REF, 33'h2222);
      // auxiliary adders per reference source, then ratio
      apb(OFS_FUNC_SEL, 1, {11'h0, FN_NONE, 3'h0, FN_AUX2, 3'h0, FN_AUX1});
      secondary_ref <= 16'h0500;
      step_ref <= 16'h0600;
      for (int s = 0; s < 4; s++) begin
         rnd = lfsr(rnd);
         la <= {2'b00, rnd[9:0]};
         rnd = lfsr(rnd);
         lb <= {2'b00, rnd[9:0]};
         ref_select <= 2'(s);
         wt(4);
         check(33'(freq_cmd), 33'((s == 1 ? 16'h0500 : s == 2 ? 16'h0600 : 16'h2222 + la) + lb));
      end
      apb(OFS_FUNC_SEL, 1, {11'h0, FN_RATIO, 3'h0, FN_AUX2, 3'h0, FN_AUX1});
      lc <= 12'h400;
      wt(4);
      check(33'(freq_cmd), 33'((16'h2222 + la + lb) >> 1));
      // loss supervision with input a as frequency command
      apb(OFS_FUNC_SEL, 1, 32'h0);
      apb(OFS_CTRL, 1, 32'h10);
      ref_select <= 0;
      foreach (rt[i]) begin
         la <= 12'd1000;
         apb(OFS_LOSS_RATIO, 1, 32'(rt[i]));
         wt(3 * LW);
         la <= 12'd50;
         n = 0;
         do @(posedge ref_clk); while (ref_loss !== 1'b1 && ++n < 3 * LW);
         wt(3);
         check(33'(freq_cmd), 33'(fl[i]));
         check(33'({decel_stop, ref_loss}), 33'(rt[i] == 0 ? 3 : 1));
         la <= 12'(th[i]);
         wt(4);
         check(33'(ref_loss), 33'h1);
         la <= 12'(th[i] + 1);
         wt(4);
         check(33'({freq_cmd, ref_loss}), 33'((th[i] + 1) * 2));
      end
      // interrupt status, mask and clear
      check(33'(irq), 33'h0);
      rd(OFS_INT_STAT, 33'h7);
      apb(OFS_INT_MASK, 1, 32'h1);
      wt(2);
      check(33'(irq), 33'h1);
      apb(OFS_INT_STAT, 1, 32'h7);
      rd(OFS_INT_STAT, 33'h0);
      check(33'(irq), 33'h0);
      end_sim;
   end
endmodule
bind arlm_top arlm_monitor #(.LOSS_WINDOW_CYCLES(LOSS_WINDOW_CYCLES)) u_mon (.ref_clk(ref_clk),
   .rst(rst), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .input_a_level(input_a_level), .input_b_level(input_b_level),
   .input_c_level(input_c_level), .ref_loss(ref_loss), .decel_stop(decel_stop),
   .pid_command(pid_command), .monitor_level(monitor_level));
`default_nettype wire
